// ==== hdl/hbap_pkg.sv ====
package hbap_pkg;

  // ----------------------------------------------------------------------
  // Command codes seen on the processor port.
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_ISO_SIZE_RD = 8'h30;
  localparam logic [7:0] CMD_ISO_SIZE_WR = 8'hb0;
  localparam logic [7:0] CMD_WIN_SETUP_RD = 8'h32;
  localparam logic [7:0] CMD_WIN_SETUP_WR = 8'hb2;
  localparam logic [7:0] CMD_BANK0_RD = 8'h40;
  localparam logic [7:0] CMD_BANK0_WR = 8'hc0;
  localparam logic [7:0] CMD_BANK1_RD = 8'h42;
  localparam logic [7:0] CMD_BANK1_WR = 8'hc2;
  localparam logic [7:0] CMD_WIN_DATA_RD = 8'h45;
  localparam logic [7:0] CMD_WIN_DATA_WR = 8'hc5;
  localparam logic [7:0] CMD_SWAP_RD = 8'h47;
  localparam logic [7:0] CMD_SWAP_WR = 8'hc7;

  // ----------------------------------------------------------------------
  // Field layouts and reset values.
  // ----------------------------------------------------------------------
  localparam int WIN_CNT_MSB = 31;
  localparam int WIN_CNT_LSB = 16;
  localparam int WIN_ADDR_MSB = 14;
  localparam int WIN_ADDR_LSB = 0;
  localparam int SWAP_MSB = 3;
  localparam logic [31:0] WIN_SETUP_RST = 32'h0000_0000;
  localparam logic [15:0] ISO_SIZE_RST = 16'h0000;
  localparam logic [3:0] SWAP_RST = 4'h0;
  localparam logic [15:0] BANK_START = 16'h0000;
  localparam logic [15:0] BYTES_PER_WORD = 16'h0002;

  // Buffer state register bit positions.
  localparam int BS_BANK0_FULL = 0;
  localparam int BS_BANK1_FULL = 1;
  localparam int BS_BANK0_ACTIVE = 5;
  localparam int BS_BANK1_ACTIVE = 6;
  localparam int BS_BANK0_DONE = 8;
  localparam int BS_BANK1_DONE = 9;

  // ----------------------------------------------------------------------
  // Memory and timing.
  // ----------------------------------------------------------------------
  localparam int MEM_BYTES = 4096;
  localparam int MEM_AW = 11;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SWAP_STEP_NS = 1000000;
  localparam int SWAP_STEP_CYC = SWAP_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REG_RD = 3'b001,
    ST_REG_WR = 3'b010,
    ST_WIN = 3'b011,
    ST_BANK0 = 3'b100,
    ST_BANK1 = 3'b101
  } hbap_state_t;

endpackage

// ==== hdl/hbap_mem_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface hbap_mem_if #(parameter int AW = 11);
  logic we;
  logic [AW-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport ram (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== hdl/hbap_buffer_ram.sv ====
`timescale 1ns/10ps
`default_nettype none
module hbap_buffer_ram #(
  parameter int AW = hbap_pkg::MEM_AW
) (
  input wire logic clk,
  hbap_mem_if.ram mem
);
  // ----------------------------------------------------------------------
  // Word-wide transfer buffer with one cycle of read latency.
  // ----------------------------------------------------------------------
  logic [15:0] words [0:(1<<AW)-1];
  logic [15:0] rdata_ff;

  // Contents are not reset, as a software reset keeps the buffer intact.
  always_ff @(posedge clk) begin
    if (mem.we) begin
      words[mem.addr] <= mem.wdata;
    end
    rdata_ff <= words[mem.addr];
  end

  assign mem.rdata = rdata_ff;
endmodule // hbap_buffer_ram
`default_nettype wire

// ==== hdl/hbap_top.sv ====
// Notes on behaviour
// - Codes 32h/B2h read/write window setup.
// - Setup: count 31:16, address 14:0.
// - Window reaches any list buffer location.
// - Window data port, codes 45h/C5h.
// - Codes 30h/B0h access ISO size.
// - One size serves both ISO banks.
// - Bank 0 port, codes 40h/C0h.
// - Bank 1 port, codes 42h/C2h.
// - Bank ports always start at zero.
// - Pointer advances on every port access.
// - Bank count reached: done flag, state update.
// - Codes 47h/C7h access swap interval.
// - Swap interval 0..15 ms, 1 ms steps.
// - State bits 9:8 read, 1:0 processing.
// - State bits 6:5 host accessing bank.
`timescale 1ns/10ps
`default_nettype none
module hbap_top #(
  parameter int SWAP_STEP_CYCLES = hbap_pkg::SWAP_STEP_CYC,
  parameter int AW = hbap_pkg::MEM_AW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic data_wr,
  input wire logic [15:0] data_in,
  input wire logic data_rd,
  output logic [15:0] data_out,
  output logic data_out_valid,
  input wire logic [15:0] transfer_byte_count,
  input wire logic [1:0] ctrl_bank_read_done,
  input wire logic transfer_done_clr,
  output logic transfer_done_flag,
  output logic [15:0] buffer_state,
  output logic [15:0] iso_buffer_size,
  output logic active_bank
);
  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  // True while the byte pointer is still below the byte limit.
  function automatic logic in_range(input logic [15:0] ptr, input logic [15:0] lim);
    in_range = ptr < lim;
  endfunction

  // Byte pointer after one word, saturating at the limit.
  function automatic logic [15:0] step(input logic [15:0] ptr, input logic [15:0] lim);
    logic [16:0] sum;
    sum = {1'b0, ptr} + {1'b0, hbap_pkg::BYTES_PER_WORD};
    step = (sum > {1'b0, lim}) ? lim : sum[15:0];
  endfunction

  // ----------------------------------------------------------------------
  // State and registers.
  // ----------------------------------------------------------------------
  hbap_pkg::hbap_state_t state_ff, nxt_state;
  logic [7:0] cmd_ff, nxt_cmd;
  logic phase_ff, nxt_phase;
  logic [15:0] ptr_ff, nxt_ptr;
  logic [31:0] win_setup_ff, nxt_win_setup;
  logic [15:0] iso_size_ff, nxt_iso_size;
  logic [3:0] swap_ff, nxt_swap;
  logic done_flag_ff, nxt_done_flag;
  logic [15:0] bstate_ff, nxt_bstate;
  logic rd_pend_ff, nxt_rd_pend;
  logic rd_mem_ff, nxt_rd_mem;
  logic [15:0] rd_reg_ff, nxt_rd_reg;
  logic [15:0] dout_ff, nxt_dout;
  logic dval_ff, nxt_dval;
  logic [31:0] tick_ff, nxt_tick;
  logic [3:0] ms_ff, nxt_ms;
  logic bank_ff, nxt_bank;

  hbap_mem_if #(.AW(AW)) mem ();

  hbap_buffer_ram #(.AW(AW)) u_ram (
    .clk(clk),
    .mem(mem)
  );

  logic [15:0] win_count;
  logic [15:0] win_start;
  logic [15:0] limit;
  logic [15:0] base;
  logic [15:0] byte_addr;
  logic access;
  logic in_data;
  assign win_count = win_setup_ff[hbap_pkg::WIN_CNT_MSB:hbap_pkg::WIN_CNT_LSB];
  assign win_start = {1'b0, win_setup_ff[hbap_pkg::WIN_ADDR_MSB:hbap_pkg::WIN_ADDR_LSB]};
  assign in_data = (state_ff == hbap_pkg::ST_WIN) || (state_ff == hbap_pkg::ST_BANK0) ||
                   (state_ff == hbap_pkg::ST_BANK1);
  assign access = in_data && (data_wr || data_rd) && in_range(ptr_ff, limit);

  // Window uses its own start and count; banks start at zero of their bank and use the
  // transfer counter. Bank 1 sits directly above bank 0 since both share one size.
  always_comb begin
    case (state_ff)
      hbap_pkg::ST_WIN: begin
        base = win_start;
        limit = win_count;
      end
      hbap_pkg::ST_BANK0: begin
        base = hbap_pkg::BANK_START;
        limit = transfer_byte_count;
      end
      hbap_pkg::ST_BANK1: begin
        base = hbap_pkg::BANK_START + iso_size_ff;
        limit = transfer_byte_count;
      end
      default: begin
        base = hbap_pkg::BANK_START;
        limit = hbap_pkg::BANK_START;
      end
    endcase
    byte_addr = base + ptr_ff;
  end

  // Word address into the buffer; addresses past the buffer wrap.
  assign mem.addr = byte_addr[AW:1];
  assign mem.wdata = data_in;
  assign mem.we = access && data_wr && cmd_ff[7];

  // ----------------------------------------------------------------------
  // Command decode and access sequencing.
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_phase = phase_ff;
    nxt_ptr = ptr_ff;
    nxt_win_setup = win_setup_ff;
    nxt_iso_size = iso_size_ff;
    nxt_swap = swap_ff;
    nxt_done_flag = done_flag_ff;
    nxt_bstate = bstate_ff;
    if (transfer_done_clr) begin
      nxt_done_flag = 1'b0;
    end
    // Controller reports a bank read; host writing to it later clears the mark.
    if (ctrl_bank_read_done[0]) begin
      nxt_bstate[hbap_pkg::BS_BANK0_DONE] = 1'b1;
      nxt_bstate[hbap_pkg::BS_BANK0_FULL] = 1'b0;
    end
    if (ctrl_bank_read_done[1]) begin
      nxt_bstate[hbap_pkg::BS_BANK1_DONE] = 1'b1;
      nxt_bstate[hbap_pkg::BS_BANK1_FULL] = 1'b0;
    end
    if (cmd_valid) begin
      // A new command always ends whatever access was in progress.
      nxt_cmd = cmd_code;
      nxt_phase = 1'b0;
      nxt_ptr = hbap_pkg::BANK_START;
      nxt_bstate[hbap_pkg::BS_BANK0_ACTIVE] = 1'b0;
      nxt_bstate[hbap_pkg::BS_BANK1_ACTIVE] = 1'b0;
      case (cmd_code)
        hbap_pkg::CMD_ISO_SIZE_RD, hbap_pkg::CMD_WIN_SETUP_RD, hbap_pkg::CMD_SWAP_RD:
          nxt_state = hbap_pkg::ST_REG_RD;
        hbap_pkg::CMD_ISO_SIZE_WR, hbap_pkg::CMD_WIN_SETUP_WR, hbap_pkg::CMD_SWAP_WR:
          nxt_state = hbap_pkg::ST_REG_WR;
        hbap_pkg::CMD_WIN_DATA_RD, hbap_pkg::CMD_WIN_DATA_WR:
          nxt_state = hbap_pkg::ST_WIN;
        hbap_pkg::CMD_BANK0_RD, hbap_pkg::CMD_BANK0_WR: begin
          nxt_state = hbap_pkg::ST_BANK0;
          nxt_bstate[hbap_pkg::BS_BANK0_ACTIVE] = 1'b1;
          if (cmd_code[7]) begin
            nxt_bstate[hbap_pkg::BS_BANK0_DONE] = 1'b0;
          end
        end
        hbap_pkg::CMD_BANK1_RD, hbap_pkg::CMD_BANK1_WR: begin
          nxt_state = hbap_pkg::ST_BANK1;
          nxt_bstate[hbap_pkg::BS_BANK1_ACTIVE] = 1'b1;
          if (cmd_code[7]) begin
            nxt_bstate[hbap_pkg::BS_BANK1_DONE] = 1'b0;
          end
        end
        default: nxt_state = hbap_pkg::ST_IDLE;
      endcase
    end else begin
      case (state_ff)
        hbap_pkg::ST_REG_RD: begin
          // The 32-bit setup register goes out low word first, then high word.
          if (data_rd) begin
            if (cmd_ff == hbap_pkg::CMD_WIN_SETUP_RD && !phase_ff) begin
              nxt_phase = 1'b1;
            end else begin
              nxt_state = hbap_pkg::ST_IDLE;
            end
          end
        end
        hbap_pkg::ST_REG_WR: begin
          if (data_wr) begin
            case (cmd_ff)
              hbap_pkg::CMD_ISO_SIZE_WR: begin
                nxt_iso_size = data_in;
                nxt_state = hbap_pkg::ST_IDLE;
              end
              hbap_pkg::CMD_SWAP_WR: begin
                nxt_swap = data_in[hbap_pkg::SWAP_MSB:0];
                nxt_state = hbap_pkg::ST_IDLE;
              end
              hbap_pkg::CMD_WIN_SETUP_WR: begin
                if (!phase_ff) begin
                  nxt_win_setup[hbap_pkg::WIN_CNT_LSB-1:0] = data_in;
                  nxt_win_setup[hbap_pkg::WIN_ADDR_MSB+1] = 1'b0;
                  nxt_phase = 1'b1;
                end else begin
                  nxt_win_setup[hbap_pkg::WIN_CNT_MSB:hbap_pkg::WIN_CNT_LSB] = data_in;
                  nxt_state = hbap_pkg::ST_IDLE;
                end
              end
              default: nxt_state = hbap_pkg::ST_IDLE;
            endcase
          end
        end
        hbap_pkg::ST_WIN, hbap_pkg::ST_BANK0, hbap_pkg::ST_BANK1: begin
          if (access) begin
            nxt_ptr = step(ptr_ff, limit);
            if (state_ff != hbap_pkg::ST_WIN && !in_range(step(ptr_ff, limit), limit)) begin
              nxt_done_flag = 1'b1;
              if (state_ff == hbap_pkg::ST_BANK0) begin
                nxt_bstate[hbap_pkg::BS_BANK0_ACTIVE] = 1'b0;
                nxt_bstate[hbap_pkg::BS_BANK0_FULL] = cmd_ff[7];
              end else begin
                nxt_bstate[hbap_pkg::BS_BANK1_ACTIVE] = 1'b0;
                nxt_bstate[hbap_pkg::BS_BANK1_FULL] = cmd_ff[7];
              end
              nxt_state = hbap_pkg::ST_IDLE;
            end
          end
        end
        default: nxt_state = hbap_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read answer path: register values are staged to match buffer latency.
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_rd_pend = data_rd && !cmd_valid &&
                  (state_ff == hbap_pkg::ST_REG_RD || (in_data && !cmd_ff[7]));
    nxt_rd_mem = access;
    case (cmd_ff)
      hbap_pkg::CMD_ISO_SIZE_RD: nxt_rd_reg = iso_size_ff;
      hbap_pkg::CMD_SWAP_RD: nxt_rd_reg = {12'h000, swap_ff};
      hbap_pkg::CMD_WIN_SETUP_RD: nxt_rd_reg = phase_ff ? win_count : win_setup_ff[hbap_pkg::WIN_CNT_LSB-1:0];
      default: nxt_rd_reg = 16'h0000;
    endcase
    // Window reads past the byte count answer zero rather than stale buffer data.
    nxt_dval = rd_pend_ff;
    nxt_dout = dout_ff;
    if (rd_pend_ff) begin
      nxt_dout = rd_mem_ff ? mem.rdata : rd_reg_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Bank swap timer: one step per millisecond, zero holds the banks still.
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_tick = tick_ff;
    nxt_ms = ms_ff;
    nxt_bank = bank_ff;
    if (swap_ff == hbap_pkg::SWAP_RST) begin
      nxt_tick = '0;
      nxt_ms = '0;
    end else if (tick_ff == 32'(SWAP_STEP_CYCLES - 1)) begin
      nxt_tick = '0;
      if (ms_ff + 4'h1 >= swap_ff) begin
        nxt_ms = '0;
        nxt_bank = !bank_ff;
      end else begin
        nxt_ms = ms_ff + 4'h1;
      end
    end else begin
      nxt_tick = tick_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= hbap_pkg::ST_IDLE;
      cmd_ff <= 8'h00;
      phase_ff <= 1'b0;
      ptr_ff <= hbap_pkg::BANK_START;
      win_setup_ff <= hbap_pkg::WIN_SETUP_RST;
      iso_size_ff <= hbap_pkg::ISO_SIZE_RST;
      swap_ff <= hbap_pkg::SWAP_RST;
      done_flag_ff <= 1'b0;
      bstate_ff <= 16'h0000;
      rd_pend_ff <= 1'b0;
      rd_mem_ff <= 1'b0;
      rd_reg_ff <= 16'h0000;
      dout_ff <= 16'h0000;
      dval_ff <= 1'b0;
      tick_ff <= 32'h0;
      ms_ff <= 4'h0;
      bank_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      phase_ff <= nxt_phase;
      ptr_ff <= nxt_ptr;
      win_setup_ff <= nxt_win_setup;
      iso_size_ff <= nxt_iso_size;
      swap_ff <= nxt_swap;
      done_flag_ff <= nxt_done_flag;
      bstate_ff <= nxt_bstate;
      rd_pend_ff <= nxt_rd_pend;
      rd_mem_ff <= nxt_rd_mem;
      rd_reg_ff <= nxt_rd_reg;
      dout_ff <= nxt_dout;
      dval_ff <= nxt_dval;
      tick_ff <= nxt_tick;
      ms_ff <= nxt_ms;
      bank_ff <= nxt_bank;
    end
  end

  assign data_out = dout_ff;
  assign data_out_valid = dval_ff;
  assign transfer_done_flag = done_flag_ff;
  assign buffer_state = bstate_ff;
  assign iso_buffer_size = iso_size_ff;
  assign active_bank = bank_ff;
endmodule // hbap_top
`default_nettype wire

// ==== testbench/hbap_top_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// Port checks for the buffer access block.
// ----
module hbap_top_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic data_out_valid,
  input wire logic [1:0] ctrl_bank_read_done,
  input wire logic transfer_done_clr,
  input wire logic transfer_done_flag,
  input wire logic [15:0] buffer_state,
  input wire logic [15:0] iso_buffer_size
);
  // One clock domain, so reset masks every check from here.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // A read or write command, a quiet cycle, then a lone read strobe.
  sequence s_rd_cmd;
    cmd_valid && (cmd_code == hbap_pkg::CMD_BANK0_RD || cmd_code == hbap_pkg::CMD_WIN_DATA_RD);
  endsequence
  sequence s_wr_cmd;
    cmd_valid && cmd_code[7];
  endsequence
  sequence s_lone_rd;
    !cmd_valid ##1 (data_rd && !cmd_valid);
  endsequence
  property p_valid_cause;
    data_out_valid |-> $past(data_rd, 2);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("answer without strobe");
  property p_valid_due;
    s_rd_cmd ##1 s_lone_rd |-> ##2 data_out_valid;
  endproperty
  a_valid_due: assert property (p_valid_due) else $error("read answer missing");
  property p_wr_refuse;
    s_wr_cmd ##1 s_lone_rd |-> ##2 !data_out_valid;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("read answered in write state");
  property p_done_rose;
    $rose(transfer_done_flag) |-> $past(data_wr || data_rd);
  endproperty
  a_done_rose: assert property (p_done_rose) else $error("done flag without access");
  property p_flag_hold;
    transfer_done_flag && !transfer_done_clr |=> transfer_done_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("done flag dropped");
  property p_rd_done_bit;
    ctrl_bank_read_done[1] && !cmd_valid && !data_wr |=> buffer_state[9] && !buffer_state[1];
  endproperty
  a_rd_done_bit: assert property (p_rd_done_bit) else $error("bank1 read state wrong");
  property p_host_clear;
    cmd_valid && cmd_code[6:0] != 7'h40 && cmd_code[6:0] != 7'h42 |=> buffer_state[6:5] == 2'b00;
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("host access bit stuck");
  property p_size_change;
    $changed(iso_buffer_size) |-> $past(data_wr);
  endproperty
  a_size_change: assert property (p_size_change) else $error("size moved without write");
endmodule // hbap_top_asserts
`default_nettype wire

// ==== testbench/hbap_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// Host processor model: issues a command, then moves data words.
// ----
module hbap_host_model (
  input wire logic clk,
  input wire logic [15:0] data_out,
  input wire logic data_out_valid,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic data_wr,
  output logic [15:0] data_in,
  output logic data_rd
);
  // Idle port at time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    data_wr = 1'b0;
    data_in = 16'h0000;
    data_rd = 1'b0;
  end
  // Callers program window or counter before data tasks.
  task automatic send_cmd(input logic [7:0] c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c; // A stale code would hide a decoder that ignores the strobe.
  endtask
  // One word per strobe; the released bus shows the inverse.
  task automatic write_word(input logic [15:0] w);
    @(posedge clk);
    data_wr <= 1'b1;
    data_in <= w;
    @(posedge clk);
    data_wr <= 1'b0;
    data_in <= ~w;
  endtask
  // The answer lands two edges after the strobe; six edges bound the wait.
  task automatic read_word(output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk);
    data_rd <= 1'b1;
    @(posedge clk);
    data_rd <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (data_out_valid === 1'b1 && ok === 1'b0) begin
        ok = 1'b1;
        d = data_out;
      end
    end
  endtask
endmodule // hbap_host_model
`default_nettype wire

// ==== testbench/hc_buffer_access_ports_test.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// Bench: random words through every port, corner cases inline.
// ----
module hc_buffer_access_ports_test;
  logic clk, rst_n, cmd_valid, data_wr, data_rd, data_out_valid, transfer_done_clr, transfer_done_flag, active_bank, ok;
  logic [7:0] cmd_code;
  logic [1:0] ctrl_bank_read_done;
  logic [15:0] data_in, data_out, transfer_byte_count, buffer_state, iso_buffer_size, w, v, a, sz;
  logic [15:0] m [0:3];
  int mismatches, cmp_count, seed, n;
  hbap_top #(.SWAP_STEP_CYCLES(10)) dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .data_wr(data_wr), .data_in(data_in), .data_rd(data_rd), .data_out(data_out), .data_out_valid(data_out_valid),
    .transfer_byte_count(transfer_byte_count), .ctrl_bank_read_done(ctrl_bank_read_done),
    .transfer_done_clr(transfer_done_clr), .transfer_done_flag(transfer_done_flag), .buffer_state(buffer_state),
    .iso_buffer_size(iso_buffer_size), .active_bank(active_bank));
  hbap_host_model host (.clk(clk), .data_out(data_out), .data_out_valid(data_out_valid), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .data_wr(data_wr), .data_in(data_in), .data_rd(data_rd));
  // Shared compare, read, register and window helpers.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic rd(output logic [15:0] d);
    logic good;
    host.read_word(d, good);
    if (good !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
    host.send_cmd(c);
    host.write_word(d);
  endtask
  // Bit 15 is driven high on purpose: it must read back as zero.
  task automatic setup(input logic [15:0] ad, input logic [15:0] cnt);
    host.send_cmd(hbap_pkg::CMD_WIN_SETUP_WR);
    host.write_word({1'b1, ad[14:0]});
    host.write_word(cnt);
  endtask
  task automatic wait_toggle(output int c);
    logic b;
    b = active_bank;
    c = 0;
    while (active_bank === b && c < 100) begin
      @(posedge clk);
      c++;
    end
    if (c >= 100) begin
      mismatches++;
      summarize();
    end
  endtask
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    transfer_byte_count = 16'h0000;
    ctrl_bank_read_done = 2'b00;
    transfer_done_clr = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    seed = 28;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    host.send_cmd(hbap_pkg::CMD_WIN_SETUP_RD);
    rd(w);
    rd(v);
    check({v, w}, 32'h0000_0000);
    host.send_cmd(hbap_pkg::CMD_ISO_SIZE_RD);
    rd(w);
    check(w, 16'h0000);
    host.send_cmd(hbap_pkg::CMD_SWAP_RD);
    rd(w);
    check(w[3:0], 4'h0);
    host.send_cmd(8'hd5);
    host.read_word(w, ok);
    check(ok, 1'b0);
    $display("test reset values done");
    a = 16'($random(seed));
    v = 16'($random(seed));
    setup(a, v);
    host.send_cmd(hbap_pkg::CMD_WIN_SETUP_RD);
    rd(w);
    check(w, {1'b0, a[14:0]});
    rd(w);
    check(w, v);
    sz = 16'h0100 | (16'($random(seed)) & 16'h00fe);
    wr_reg(hbap_pkg::CMD_ISO_SIZE_WR, sz);
    host.send_cmd(hbap_pkg::CMD_ISO_SIZE_RD);
    rd(w);
    check(w, sz);
    check(iso_buffer_size, sz);
    $display("test registers done");
    // Window: a fourth word past the count must not land on the marker.
    a = 16'h0800 | (16'($random(seed)) & 16'h03fe);
    setup(a + 16'h0006, 16'h0002);
    wr_reg(hbap_pkg::CMD_WIN_DATA_WR, 16'h5a5a);
    setup(a, 16'h0006);
    host.send_cmd(hbap_pkg::CMD_WIN_DATA_WR);
    for (n = 0; n < 4; n++) begin
      m[n] = 16'($random(seed));
      host.write_word(m[n]);
    end
    setup(a, 16'h0008);
    host.send_cmd(hbap_pkg::CMD_WIN_DATA_RD);
    for (n = 0; n < 4; n++) begin
      rd(w);
      check(w, (n < 3) ? m[n] : 16'h5a5a);
    end
    setup(a, 16'h0002);
    host.send_cmd(hbap_pkg::CMD_WIN_DATA_RD);
    rd(w);
    rd(w);
    check(w, 16'h0000);
    $display("test window done");
    // Bank writes of four bytes each, read back through the window.
    transfer_byte_count <= 16'h0004;
    for (n = 0; n < 4; n++) begin
      m[n] = 16'($random(seed));
    end
    host.send_cmd(hbap_pkg::CMD_BANK0_WR);
    host.write_word(m[0]);
    host.write_word(m[1]);
    @(posedge clk);
    check({transfer_done_flag, buffer_state[0]}, 2'b11);
    transfer_done_clr <= 1'b1;
    @(posedge clk);
    transfer_done_clr <= 1'b0;
    @(posedge clk);
    check(transfer_done_flag, 1'b0);
    host.send_cmd(hbap_pkg::CMD_BANK1_WR);
    host.write_word(m[2]);
    check(buffer_state[6], 1'b1);
    host.write_word(m[3]);
    @(posedge clk);
    check(buffer_state[1], 1'b1);
    for (n = 0; n < 2; n++) begin
      setup((n == 0) ? 16'h0000 : sz, 16'h0004);
      host.send_cmd(hbap_pkg::CMD_WIN_DATA_RD);
      rd(w);
      rd(v);
      check({w, v}, {m[2 * n], m[2 * n + 1]});
    end
    // Clear the flag left by the bank 1 write so that the read must set it again.
    transfer_done_clr <= 1'b1;
    @(posedge clk);
    transfer_done_clr <= 1'b0;
    host.send_cmd(hbap_pkg::CMD_BANK0_RD);
    rd(w);
    check({w, transfer_done_flag, buffer_state[5]}, {m[0], 2'b01});
    rd(w);
    check({w, transfer_done_flag, buffer_state[5]}, {m[1], 2'b10});
    host.send_cmd(hbap_pkg::CMD_BANK1_RD);
    rd(w);
    check({w, buffer_state[6:5]}, {m[2], 2'b10});
    ctrl_bank_read_done <= 2'b11;
    @(posedge clk);
    ctrl_bank_read_done <= 2'b00;
    @(posedge clk);
    check({buffer_state[9:8], buffer_state[1:0]}, 4'b1100);
    $display("test banks done");
    // Swap every 2 ms, with 10 cycles standing for 1 ms.
    wr_reg(hbap_pkg::CMD_SWAP_WR, 16'h0002);
    host.send_cmd(hbap_pkg::CMD_SWAP_RD);
    rd(w);
    check(w[3:0], 4'h2);
    wait_toggle(n);
    wait_toggle(n);
    check(n, 20);
    $display("test swap done");
    // A second reset in mid-run clears every register but leaves the buffer contents alone.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check({transfer_done_flag, active_bank, iso_buffer_size}, 18'h00000);
    check(buffer_state, 16'h0000);
    setup(16'h0000, 16'h0002);
    host.send_cmd(hbap_pkg::CMD_WIN_DATA_RD);
    rd(w);
    check(w, m[0]);
    $display("test reset again done");
    summarize();
  end
endmodule // hc_buffer_access_ports_test
bind hbap_top hbap_top_asserts chk (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .data_wr(data_wr), .data_rd(data_rd), .data_out_valid(data_out_valid), .ctrl_bank_read_done(ctrl_bank_read_done),
  .transfer_done_clr(transfer_done_clr), .transfer_done_flag(transfer_done_flag), .buffer_state(buffer_state),
  .iso_buffer_size(iso_buffer_size));
`default_nettype wire
